/* File: rtl/bpm_mode_ctrl.sv */
// Purpose: Mode and gate-command logic of a current-mode step-down stage
// Assumes: comparator inputs are synchronous to sys_clk
// Notes: osc_tick and sync_tick are one-cycle period pulses
`timescale 1ns/10ps
module bpm_mode_ctrl
  import bpm_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Period sources
  input wire logic osc_tick,
  input wire logic sync_tick,
  input wire logic sync_sel,
  // Analog comparators
  input wire logic pwm_off_req,
  input wire logic ilim_trip,
  input wire logic light_load_entry_threshold,
  input wire logic light_load_reference,
  // Outputs
  output logic switch_on,
  output logic driver_en,
  output logic ref_sel_pfm,
  output logic low_power_en
);
  bpm_mode_t mode_q, mode_d;
  logic sw_q, sw_d;
  logic [7:0] on_q, on_d;
  logic [7:0] off_q, off_d;
  logic ref_q;
  logic [7:0] past_on;
  logic ret_q, ret_d;

  bpm_rate_if rif ();

  // ****************************************
  // Helpers
  // ****************************************
  // Saturating step: a long full-duty run must not wrap the counters
  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == 8'hFF) ? v : v + 8'h01;
  endfunction

  // ****************************************
  // Decode
  // ****************************************
  wire logic in_pfm = (mode_q == BPM_MODE_PFM);
  // Sync clock is ignored in PFM; the period comes from the pins only in PWM
  wire logic period_start = sync_sel ? (sync_tick && !in_pfm)
                                     : osc_tick;
  // On counter reads 0 in the first on-cycle, so the last one sees MIN - 1
  wire logic min_done = (on_q >= MIN_ON_CYC - 8'h01);
  wire logic off_ok = (off_q >= MIN_OFF_CYC);
  // Limit trip always wins, minimum on-time only masks the comparator
  wire logic pwm_end = ilim_trip || (pwm_off_req && min_done);
  wire logic ref_rise = light_load_reference && !ref_q;
  wire logic pfm_fire = in_pfm && ref_rise && !sw_q && off_ok;
  wire logic pfm_end = ilim_trip || min_done;
  wire logic go_pfm = !in_pfm && light_load_entry_threshold;
  // A rate flag that lands mid-pulse is held until the switch is off
  wire logic ret_pend = rif.rate_high || ret_q;
  wire logic go_pwm = in_pfm && ret_pend && !sw_q;
  assign ret_d = in_pfm && ret_pend && !go_pwm;

  assign rif.period_tick = osc_tick;
  assign rif.pulse_evt = pfm_fire;
  assign rif.clr = !in_pfm;

  bpm_rate_mon u_rate (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .rif(rif)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    mode_d = mode_q;
    sw_d = sw_q;
    unique case (mode_q)
      BPM_MODE_PWM: begin
        if (go_pfm) begin
          mode_d = BPM_MODE_PFM;
          sw_d = 1'b0;
        end else if (sw_q && pwm_end) begin
          sw_d = 1'b0;
        end else if (period_start && !ilim_trip) begin
          sw_d = 1'b1;
        end
      end
      BPM_MODE_PFM: begin
        if (go_pwm) begin
          mode_d = BPM_MODE_PWM;
        end else if (sw_q && pfm_end) begin
          sw_d = 1'b0;
        end else if (pfm_fire) begin
          sw_d = 1'b1;
        end
      end
    endcase
  end

  // On counter restarts at each new pulse; full duty keeps it saturated
  assign on_d = (sw_d && !sw_q) ? 8'h00 : sw_q ? sat_inc(on_q) : on_q;
  assign off_d = sw_q ? 8'h00 : sat_inc(off_q);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= BPM_MODE_PWM;
      sw_q <= 1'b0;
      on_q <= 8'h00;
      off_q <= 8'hFF;
      ref_q <= 1'b0;
      ret_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      sw_q <= sw_d;
      on_q <= on_d;
      off_q <= off_d;
      ref_q <= light_load_reference;
      ret_q <= ret_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign switch_on = sw_q;
  assign driver_en = !in_pfm || sw_q;
  assign ref_sel_pfm = in_pfm;
  assign low_power_en = in_pfm;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      past_on <= 8'h00;
    end else begin
      past_on <= on_q;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // A pulse cut by the limit or by PFM entry may be shorter
  min_on_width_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $fell(sw_q) && !$past(ilim_trip) && !$past(go_pfm)
    |-> past_on >= MIN_ON_CYC - 8'h01)
    else $error("pulse shorter than minimum");
  ilim_end_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    sw_q && ilim_trip |=> !sw_q) else $error("limit did not end pulse");
  lim_block_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !in_pfm && !sw_q && ilim_trip |=> !sw_q)
    else $error("period started under limit");
  full_duty_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    sw_q && !in_pfm && !pwm_off_req && !ilim_trip
    && !light_load_entry_threshold |=> sw_q)
    else $error("switch dropped without cause");
  pwm_start_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !in_pfm && !sw_q && osc_tick && !sync_sel && !ilim_trip
    && !light_load_entry_threshold |=> sw_q)
    else $error("period start missed");
  pfm_entry_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !in_pfm && light_load_entry_threshold |=> in_pfm && !sw_q)
    else $error("no PFM entry");
  pfm_off_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    in_pfm && !sw_q |-> !driver_en) else $error("driver on idle");
  mode_out_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(in_pfm) |-> low_power_en && ref_sel_pfm)
    else $error("mode outputs wrong");
  pfm_ref_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $fell(in_pfm) |-> !ref_sel_pfm && !low_power_en && $past(ret_pend))
    else $error("bad PFM exit");
  pfm_pulse_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    pfm_fire && !go_pwm |=> sw_q) else $error("PFM pulse missed");
  pfm_width_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $fell(sw_q) && in_pfm && $past(in_pfm) && !$past(ilim_trip)
    |-> past_on == MIN_ON_CYC - 8'h01)
    else $error("PFM pulse not minimum width");
  pfm_gap_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(sw_q) && in_pfm && $past(in_pfm) |-> $past(off_q) >= MIN_OFF_CYC)
    else $error("PFM pulse too close to last");
  // Worst case: flag lands as a pulse starts, exit follows its end
  ret_done_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    in_pfm && rif.rate_high |-> ##[1:7] !in_pfm)
    else $error("rate flag did not return to PWM");
  sync_ign_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    in_pfm && !sw_q && sync_sel && !pfm_fire |=> !sw_q)
    else $error("sync used in PFM");
  sync_pwm_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !in_pfm && !sw_q && sync_sel && sync_tick && !ilim_trip
    && !light_load_entry_threshold |=> sw_q)
    else $error("sync start missed in PWM");
  osc_ign_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !in_pfm && !sw_q && sync_sel && !sync_tick |=> !sw_q)
    else $error("oscillator used while synced");
  reset_state_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> !sw_q && !in_pfm && !low_power_en && !ref_sel_pfm)
    else $error("state after reset wrong");
endmodule // bpm_mode_ctrl

/* File: common/bpm_pkg.sv */
// Purpose: Shared constants and types for the converter mode logic
// Assumes: 50 MHz system clock
// Notes: Times are held in ns and converted to cycles here
package bpm_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int MIN_ON_NS = 100;
  localparam int MIN_ON_CYC_I = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] MIN_ON_CYC = 8'(MIN_ON_CYC_I < 1 ? 1 : MIN_ON_CYC_I);
  localparam int MIN_OFF_NS = 200;
  localparam int MIN_OFF_CYC_I =
    (MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] MIN_OFF_CYC =
    8'(MIN_OFF_CYC_I < 1 ? 1 : MIN_OFF_CYC_I);
  // ****************************************
  // Rate monitor
  // ****************************************
  // Six pulses over five oscillator periods is the 1.20 return ratio
  localparam logic [7:0] RATE_WIN_PERIODS = 8'h05;
  localparam logic [7:0] RATE_RETURN_COUNT = 8'h06;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [0:0] {
    BPM_MODE_PWM = 1'b0,
    BPM_MODE_PFM = 1'b1
  } bpm_mode_t;
endpackage

/* File: common/bpm_rate_if.sv */
// Purpose: Carries pulse events and the return decision between modules
// Assumes: single clock
// Notes: All signals are one-cycle pulses except clr
`timescale 1ns/10ps
interface bpm_rate_if;
  logic period_tick;
  logic pulse_evt;
  logic clr;
  logic rate_high;
  modport ctrl (output period_tick, output pulse_evt, output clr,
    input rate_high);
  modport mon (input period_tick, input pulse_evt, input clr,
    output rate_high);
endinterface

/* File: rtl/bpm_rate_mon.sv */
// Purpose: Counts light-load pulses over whole oscillator periods
// Assumes: period_tick is one pulse per oscillator period
// Notes: rate_high is a one-cycle pulse
`timescale 1ns/10ps
module bpm_rate_mon
  import bpm_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Event carrier
  bpm_rate_if.mon rif
);
  logic [7:0] win_q, win_d;
  logic [7:0] cnt_q, cnt_d;
  logic rate_q, rate_d;
  wire logic win_end = rif.period_tick && (win_q == RATE_WIN_PERIODS - 8'h01);
  wire logic [7:0] cnt_inc = (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;
  wire logic [7:0] cnt_now = rif.pulse_evt ? cnt_inc : cnt_q;

  // ****************************************
  // Window counter
  // ****************************************
  assign win_d = (rif.clr || win_end) ? 8'h00 :
                 rif.period_tick ? win_q + 8'h01 : win_q;
  assign cnt_d = (rif.clr || win_end) ? 8'h00 : cnt_now;
  // Compare at window end: 1.20 pulses per period on average or more
  assign rate_d = !rif.clr && win_end
                  && (cnt_now >= RATE_RETURN_COUNT);
  assign rif.rate_high = rate_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      win_q <= 8'h00;
      cnt_q <= 8'h00;
      rate_q <= 1'b0;
    end else begin
      win_q <= win_d;
      cnt_q <= cnt_d;
      rate_q <= rate_d;
    end
  end

  win_bound_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    win_q < RATE_WIN_PERIODS) else $error("window count out of range");
  rate_cause_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    rate_q |-> $past(win_end)) else $error("rate flag outside window end");
endmodule // bpm_rate_mon

/* File: verification/bpm_far_model.sv */
// Purpose: Far side: oscillator tick and on-time comparator
// Assumes: switch_on is registered on sys_clk
// Notes: on_cyc of zero never asks for switch-off
`timescale 1ns/10ps
module bpm_far_model #(
  parameter int PER = 40
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Gate command and on-time setting
  input wire logic switch_on,
  input wire logic [7:0] on_cyc,
  // Oscillator tick and comparator output
  output logic osc_tick,
  output logic pwm_off_req
);
  int per_q;
  logic [7:0] on_q;
  // Comparator is quiet while the switch is off
  assign pwm_off_req = switch_on && (on_cyc != 8'h00) && (on_q >= on_cyc);
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_q <= 0;
      on_q <= 8'h00;
      osc_tick <= 1'b0;
    end else begin
      per_q <= #1 (per_q == PER - 1) ? 0 : per_q + 1;
      osc_tick <= #1 (per_q == PER - 1);
      on_q <= #1 switch_on ? on_q + 8'h01 : 8'h00;
    end
  end
endmodule // bpm_far_model

/* File: verification/test_bpm_mode_ctrl.sv */
// Purpose: Self-checking bench for the converter mode logic
// Assumes: oscillator period of 40 cycles from the far model
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/10ps
module test_bpm_mode_ctrl;
  import bpm_pkg::*;
  localparam int PER = 40;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sync_tick = 1'b0;
  logic sync_sel = 1'b0;
  logic ilim = 1'b0;
  logic entry = 1'b0;
  logic ll_ref = 1'b0;
  logic [7:0] on_cyc = 8'h02;
  logic osc_tick, off_req, switch_on, driver_en, ref_sel_pfm, low_power_en;
  int num_errors = 0;
  int check_count = 0;
  int n, w, h;
  always #10 sys_clk = ~sys_clk;
  bpm_far_model #(.PER(PER)) far_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .switch_on(switch_on), .on_cyc(on_cyc), .osc_tick(osc_tick),
    .pwm_off_req(off_req));
  bpm_mode_ctrl dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .osc_tick(osc_tick), .sync_tick(sync_tick), .sync_sel(sync_sel),
    .pwm_off_req(off_req), .ilim_trip(ilim),
    .light_load_entry_threshold(entry), .light_load_reference(ll_ref),
    .switch_on(switch_on), .driver_en(driver_en),
    .ref_sel_pfm(ref_sel_pfm), .low_power_en(low_power_en));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // Bounded so a stuck gate cannot hang the run
  task automatic pulse_w(output int n, output int w);
    n = 0;
    w = 0;
    while (switch_on !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    while (switch_on === 1'b1 && w < 200) begin
      cyc(1);
      w++;
    end
  endtask
  task automatic cnt_hi(input int c, output int h);
    h = 0;
    repeat (c) begin
      cyc(1);
      if (switch_on === 1'b1) h++;
    end
  endtask
  task automatic ev(input int gap);
    ll_ref = 1'b1;
    cyc(1);
    ll_ref = 1'b0;
    cyc(gap - 1);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    chk("rst gate", 8'h00, switch_on);
    chk("rst ref", 8'h00, ref_sel_pfm);
    chk("rst lp", 8'h00, low_power_en);
    $display("test reset done");
  endtask
  task t_pwm;
    pulse_w(n, w);
    chk("min on", 8'h05, 8'(w));
    pulse_w(n, w);
    chk("min period", 8'(PER - 5), 8'(n));
    on_cyc = 8'h08;
    pulse_w(n, w);
    chk("on time", 8'h09, 8'(w));
    pulse_w(n, w);
    chk("period", 8'(PER - 9), 8'(n));
    $display("test pwm done");
  endtask
  task t_full;
    on_cyc = 8'h00;
    cyc(PER + 2);
    cnt_hi(2 * PER, h);
    chk("full duty", 8'(2 * PER), 8'(h));
    ilim = 1'b1;
    cyc(2);
    chk("limit off", 8'h00, switch_on);
    cnt_hi(PER, h);
    chk("limit hold", 8'h00, 8'(h));
    ilim = 1'b0;
    on_cyc = 8'h02;
    $display("test full duty done");
  endtask
  task t_pfm;
    entry = 1'b1;
    cyc(1);
    entry = 1'b0;
    chk("pfm ref", 8'h01, ref_sel_pfm);
    chk("pfm lp", 8'h01, low_power_en);
    chk("pfm drv", 8'h00, driver_en);
    sync_sel = 1'b1;
    repeat (3) begin
      sync_tick = 1'b1;
      cyc(1);
      sync_tick = 1'b0;
      cnt_hi(PER, h);
      chk("pfm idle", 8'h00, 8'(h));
    end
    ll_ref = 1'b1;
    cyc(1);
    ll_ref = 1'b0;
    chk("pfm drv on", 8'h01, driver_en);
    pulse_w(n, w);
    chk("pfm width", 8'h05, 8'(w));
    $display("test pfm done");
  endtask
  task t_exit;
    cyc(20);
    repeat (15) ev(44);
    chk("slow stays", 8'h01, ref_sel_pfm);
    n = 0;
    while (ref_sel_pfm === 1'b1 && n < 40) begin
      ev(20);
      n++;
    end
    chk("fast returns", 8'h01, 8'(n <= 25));
    chk("pwm lp", 8'h00, low_power_en);
    chk("pwm ref", 8'h00, ref_sel_pfm);
    chk("pwm drv", 8'h01, driver_en);
    @(posedge osc_tick);
    cyc(10);
    sync_tick = 1'b1;
    cyc(1);
    sync_tick = 1'b0;
    cyc(1);
    chk("sync pwm", 8'h01, switch_on);
    $display("test exit done");
  endtask
  initial begin
    cyc(4);
    t_reset;
    rst_n = 1'b1;
    t_pwm;
    t_full;
    t_pfm;
    t_exit;
    end_of_test;
  end
  initial begin
    #100000;
    num_errors++;
    end_of_test;
  end
endmodule // test_bpm_mode_ctrl
